// ---- hdl/board_sys_regs.vh ----
`ifndef BOARD_SYS_REGS_VH
`define BOARD_SYS_REGS_VH

// Register byte offsets on the peripheral bus.
`define OFS_LAMP 12'h008
`define OFS_SLOW 12'h024
`define OFS_VFLAG 12'h030
`define OFS_VFLAG_CLR 12'h034
`define OFS_PFLAG 12'h038
`define OFS_PFLAG_CLR 12'h03C
`define OFS_CFGSW 12'h058
`define OFS_REF 12'h05C
`define OFS_MISC 12'h060

// Field positions.
`define LAMP_MSB 7
`define CFGSW_MSB 7
`define MISC_EVENT_BIT 19
`define MISC_PRESENT_BIT 13

// Reset values.
`define LAMP_RST 8'h00
`define FLAG_RST 32'h00000000
`define COUNT_RST 32'h00000000

// Timing: rates in Hz, cycle figures derived from them.
`define SYS_CLK_HZ 250000000
`define REF_CLK_HZ 24000000
`define SLOW_TICK_HZ 100
`define REF_PER_SLOW (`REF_CLK_HZ / `SLOW_TICK_HZ)
// Phase step and modulus of the reference-rate accumulator, in MHz.
`define REF_STEP 9'h018
`define REF_MOD 9'h0FA

`endif

// ---- hdl/rate_divider.v ----
`include "board_sys_regs.vh"

module rate_divider #(
    parameter REF_PER_SLOW = `REF_PER_SLOW
) (
    clk,
    rst_b,
    ref_tick,
    slow_tick
);
    input wire clk;
    input wire rst_b;
    output reg ref_tick;
    output reg slow_tick;

    reg [8:0] phase_ff;
    reg [31:0] slow_cnt_ff;
    wire [8:0] nxt_phase;
    wire phase_wrap;

    // A phase accumulator gives exactly 24 pulses per 250 clock cycles, so the long-run
    // rate is exact; the cost is a jitter of one system cycle between pulses.
    assign nxt_phase = phase_ff + `REF_STEP;
    assign phase_wrap = (nxt_phase >= `REF_MOD);

    always @(posedge clk) begin
        if (!rst_b) begin
            phase_ff <= 9'h000;
            slow_cnt_ff <= 32'h00000000;
            ref_tick <= 1'b0;
            slow_tick <= 1'b0;
        end else begin
            phase_ff <= phase_wrap ? (nxt_phase - `REF_MOD) : nxt_phase;
            ref_tick <= phase_wrap;
            slow_tick <= 1'b0;
            if (phase_wrap) begin
                if (slow_cnt_ff == REF_PER_SLOW - 1) begin
                    slow_cnt_ff <= 32'h00000000;
                    slow_tick <= 1'b1;
                end else begin
                    slow_cnt_ff <= slow_cnt_ff + 32'h00000001;
                end
            end
        end
    end
endmodule // rate_divider

// ---- hdl/flag_bank.v ----
module flag_bank (
    clk,
    clear_n,
    set_we,
    clr_we,
    wdata,
    flags
);
    input wire clk;
    input wire clear_n;
    input wire set_we;
    input wire clr_we;
    input wire [31:0] wdata;
    output reg [31:0] flags;

    // Set and clear ports sit at different addresses, so both strobes never meet;
    // set is still given priority should they ever coincide.
    always @(posedge clk) begin
        if (!clear_n) begin
            flags <= 32'h00000000;
        end else if (set_we) begin
            flags <= flags | wdata;
        end else if (clr_we) begin
            flags <= flags & ~wdata;
        end
    end
endmodule // flag_bank

// ---- hdl/board_system_register_slice.v ----
// Function
// - Eight read-write lamp bits; one lights a lamp, zero turns it off.
// - All lamp bits clear to off on reset.
// - A 32-bit counter advances at 100 Hz, timed from the 24 MHz reference.
// - The 100 Hz counter is read-only and counts ticks since board reset.
// - Two 32-bit flag registers with software-defined meanings.
// - Flag registers read their state and change only via set and clear ports.
// - Writing ones to a set port sets those flags; zeros leave them.
// - Writing ones to a clear port clears those flags; zeros leave them.
// - The volatile flags are cleared by the board reset.
// - The persistent flags survive board reset; only power-on reset clears them.
// - On reset the eight soft switch bits load the configured value.
// - Soft switch bits are for software only, never used to configure anything.
// - A 32-bit counter advances once per 24 MHz reference cycle.
// - The 24 MHz counter is read-only; writes do not change it.
// - Board reset zeroes the 24 MHz counter, which then counts on.
// - Misc bit 19 is read-write and drives the daughterboard event output.
// - Misc bit 13 is read-only and shows whether a daughterboard is fitted.
`include "board_sys_regs.vh"

module board_system_register_slice #(
    parameter REF_PER_SLOW = `REF_PER_SLOW
) (
    clk,
    rst_b,
    power_on_reset_n,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    configured_switch_value,
    daughterboard_present,
    user_lamp_bits,
    software_event_out
);
    input wire clk;
    input wire rst_b;
    input wire power_on_reset_n;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output reg pslverr;
    input wire [7:0] configured_switch_value;
    input wire daughterboard_present;
    output wire [7:0] user_lamp_bits;
    output wire software_event_out;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.

    function is_mapped;
        input [11:0] a;
        begin
            case (a)
                `OFS_LAMP, `OFS_SLOW, `OFS_VFLAG, `OFS_VFLAG_CLR, `OFS_PFLAG,
                `OFS_PFLAG_CLR, `OFS_CFGSW, `OFS_REF, `OFS_MISC: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    wire setup_phase;
    wire wr_access;

    // Registers update on the access phase; reads are prepared in setup so that the
    // data comes straight from flip-flops with no wait state.
    assign setup_phase = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage.

    reg [7:0] lamp_ff;
    reg [7:0] cfgsw_ff;
    reg event_ff;
    reg [31:0] slow_count_ff;
    reg [31:0] ref_count_ff;
    reg present_meta_ff;
    reg present_ff;
    reg [7:0] strap_meta_ff;
    reg [7:0] strap_sync_ff;
    wire ref_tick;
    wire slow_tick;
    wire [31:0] vflags;
    wire [31:0] pflags;
    wire vflag_clear_n;

    assign user_lamp_bits = lamp_ff;
    assign software_event_out = event_ff;

    always @(posedge clk) begin
        present_meta_ff <= daughterboard_present;
        present_ff <= present_meta_ff;
    end

    // The strap comes from outside this clock domain, so it passes two flops first.
    // Reset must therefore be held for at least three edges to load a settled value.
    always @(posedge clk) begin
        strap_meta_ff <= configured_switch_value;
        strap_sync_ff <= strap_meta_ff;
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            lamp_ff <= `LAMP_RST;
            // The synchronised strap is caught by this clocked load during reset. The
            // value is held only for software; nothing in this block acts on it.
            cfgsw_ff <= strap_sync_ff;
            event_ff <= 1'b0;
        end else if (wr_access) begin
            // Only the defined bits are stored; reserved write data is dropped.
            if (paddr == `OFS_LAMP) begin
                lamp_ff <= pwdata[`LAMP_MSB:0];
            end
            if (paddr == `OFS_CFGSW) begin
                cfgsw_ff <= pwdata[`CFGSW_MSB:0];
            end
            if (paddr == `OFS_MISC) begin
                event_ff <= pwdata[`MISC_EVENT_BIT];
            end
        end
    end

    // Counters ignore every bus write and wrap naturally.
    always @(posedge clk) begin
        if (!rst_b) begin
            slow_count_ff <= `COUNT_RST;
            ref_count_ff <= `COUNT_RST;
        end else begin
            if (slow_tick) begin
                slow_count_ff <= slow_count_ff + 32'h00000001;
            end
            if (ref_tick) begin
                ref_count_ff <= ref_count_ff + 32'h00000001;
            end
        end
    end

    rate_divider #(
        .REF_PER_SLOW(REF_PER_SLOW)
    ) u_rate (
        .clk(clk),
        .rst_b(rst_b),
        .ref_tick(ref_tick),
        .slow_tick(slow_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Flag banks.

    // Power-on reset implies a board reset, so it clears the volatile bank too.
    assign vflag_clear_n = rst_b & power_on_reset_n;

    flag_bank u_vflag (
        .clk(clk),
        .clear_n(vflag_clear_n),
        .set_we(wr_access & (paddr == `OFS_VFLAG)),
        .clr_we(wr_access & (paddr == `OFS_VFLAG_CLR)),
        .wdata(pwdata),
        .flags(vflags)
    );

    flag_bank u_pflag (
        .clk(clk),
        .clear_n(power_on_reset_n),
        .set_we(wr_access & (paddr == `OFS_PFLAG)),
        .clr_we(wr_access & (paddr == `OFS_PFLAG_CLR)),
        .wdata(pwdata),
        .flags(pflags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read path.

    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        case (paddr)
            `OFS_LAMP: rd_mux[`LAMP_MSB:0] = lamp_ff;
            `OFS_SLOW: rd_mux = slow_count_ff;
            `OFS_VFLAG: rd_mux = vflags;
            `OFS_PFLAG: rd_mux = pflags;
            `OFS_CFGSW: rd_mux[`CFGSW_MSB:0] = cfgsw_ff;
            `OFS_REF: rd_mux = ref_count_ff;
            `OFS_MISC: begin
                rd_mux[`MISC_EVENT_BIT] = event_ff;
                rd_mux[`MISC_PRESENT_BIT] = present_ff;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= ~is_mapped(paddr);
        end
    end
endmodule // board_system_register_slice

// ---- verification/board_system_register_slice_assertions.sv ----
module board_system_register_slice_assertions #(
    parameter REF_PER_SLOW = 240000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [7:0] user_lamp_bits,
    input wire logic software_event_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire wr_acc = psel && penable && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    ////////////////////////////////////////////////////////////
    sequence lamp_write;
        psel && !penable && pwrite && paddr == 12'h008 ##1 wr_acc && paddr == 12'h008;
    endsequence
    AST_LAMP_WRITE:
        assert property (lamp_write |=> user_lamp_bits == $past(pwdata[7:0])) else $error("lamp write");
    AST_LAMP_READ:
        assert property (rd_setup && paddr == 12'h008 |=> prdata == {24'h000000, user_lamp_bits}
            && !pslverr) else $error("lamp read");
    AST_LAMP_HOLD:
        assert property (!(wr_acc && paddr == 12'h008) |=> $stable(user_lamp_bits)) else $error("lamp");
    AST_EVENT_WRITE:
        assert property (wr_acc && paddr == 12'h060 |=> software_event_out == $past(pwdata[19]))
            else $error("event write");
    AST_EVENT_HOLD:
        assert property (!(wr_acc && paddr == 12'h060) |=> $stable(software_event_out))
            else $error("event hold");
    AST_MISC_READ:
        assert property (rd_setup && paddr == 12'h060 |=> prdata[19] == software_event_out
            && prdata[31:20] == 12'h000 && prdata[18:14] == 5'h00 && prdata[12:0] == 13'h0000)
            else $error("misc read");
    AST_RESET_CLEAN:
        assert property ($rose(rst_b) |-> user_lamp_bits == 8'h00 && !software_event_out
            && !pslverr) else $error("reset state");
    AST_WO_PORT:
        assert property (rd_setup && (paddr == 12'h034 || paddr == 12'h03C) |=> prdata == 32'h0)
            else $error("clear port read");
    AST_CFG_READ:
        assert property (rd_setup && paddr == 12'h058 |=> prdata[31:8] == 24'h000000)
            else $error("switch read");
endmodule // board_system_register_slice_assertions

bind board_system_register_slice board_system_register_slice_assertions #(
    .REF_PER_SLOW(REF_PER_SLOW)) chk_inst (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .user_lamp_bits(user_lamp_bits), .software_event_out(software_event_out));

// ---- verification/board_system_register_slice_test.sv ----
module board_system_register_slice_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, power_on_reset_n, psel, penable, pwrite, daughterboard_present;
    logic pready, pslverr, software_event_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v, s, c, pf;
    logic [7:0] strap, user_lamp_bits;
    logic [32:0] exp_lo[$], exp_hi[$], got;
    int error_cnt, cmp_count, cyc, t0, seed, r;
    board_system_register_slice #(.REF_PER_SLOW(4)) board_system_register_slice_inst (
        .clk(clk), .rst_b(rst_b), .power_on_reset_n(power_on_reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .configured_switch_value(strap),
        .daughterboard_present(daughterboard_present), .user_lamp_bits(user_lamp_bits),
        .software_event_out(software_event_out));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    // The run should take about 1,000 cycles; far beyond that means a hang.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            conclude();
        end
    end
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0) begin
            got = {pslverr, prdata};
            cmp_count = cmp_count + 1;
            if ((^got) === 1'bx || got < exp_lo[0] || got > exp_hi[0] || pready !== 1'b1) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED read %h expected %h..%h seen %h", paddr, exp_lo[0],
                    exp_hi[0], got);
            end
            void'(exp_lo.pop_front());
            void'(exp_hi.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////
    // Transfers run back to back, so psel is only dropped by idle.
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] lo, input logic [32:0] hi);
        exp_lo.push_back(lo);
        exp_hi.push_back(hi);
        xfer(a, 1'b0, $random(seed));
    endtask
    task automatic rde(input logic [11:0] a, input logic [31:0] d);
        rd(a, {1'b0, d}, {1'b0, d});
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // The reference rate is 24 ticks per 250 clocks, with a slack for jitter and latency.
    task automatic counters();
        r = (cyc - t0) * 24 / 250;
        rd(12'h05C, 33'(r > 3 ? r - 3 : 0), 33'(r + 1));
        rd(12'h024, 33'(r > 8 ? r / 4 - 2 : 0), 33'(r / 4 + 1));
    endtask
    task automatic conclude();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        seed = 23;
        {psel, penable, pwrite, paddr, pwdata, daughterboard_present} = '0;
        {rst_b, power_on_reset_n, error_cnt, cmp_count, cyc} = '0;
        strap = 8'($random(seed));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        power_on_reset_n <= 1'b1;
        t0 = cyc;
        rde(12'h058, {24'h0, strap});
        strap <= ~strap;
        v = {24'h0, 8'($random(seed))};
        xfer(12'h008, 1'b1, v);
        rde(12'h008, v);
        for (int b = 0; b < 2; b++) begin
            s = $random(seed);
            c = $random(seed);
            xfer(12'h030 + 12'(8 * b), 1'b1, s);
            xfer(12'h034 + 12'(8 * b), 1'b1, c);
            rde(12'h030 + 12'(8 * b), s & ~c);
            rde(12'h034 + 12'(8 * b), 32'h0);
        end
        pf = s & ~c;
        daughterboard_present <= 1'b1;
        xfer(12'h060, 1'b1, 32'h00080000);
        idle(3);
        rde(12'h060, 32'h00082000);
        rd(12'h100, 33'h100000000, 33'h100000000);
        xfer(12'h05C, 1'b1, 32'hFFFFFFFF);
        xfer(12'h024, 1'b1, 32'hFFFFFFFF);
        idle(900);
        counters();
        idle(1);
        rst_b <= 1'b0;
        daughterboard_present <= 1'b0;
        idle(16);
        rst_b <= 1'b1;
        t0 = cyc;
        rde(12'h030, 32'h0);
        rde(12'h038, pf);
        rde(12'h008, 32'h0);
        rde(12'h058, {24'h0, strap});
        rde(12'h060, 32'h00000000);
        counters();
        power_on_reset_n <= 1'b0;
        idle(2);
        power_on_reset_n <= 1'b1;
        rde(12'h038, 32'h0);
        idle(2);
        conclude();
    end
endmodule // board_system_register_slice_test
